// >>> rtl/srs_top.sv
// Speed reference selector: source choice, multi-step decode, run source, APB
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ns
module srs_top #(
  parameter int GATE_CYC = srs_pkg::GATE_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  input wire srs_pkg::srs_term_t i_term,
  input wire srs_pkg::srs_analog_t i_analog,
  input wire logic i_key_run,
  input wire logic i_key_stop,
  input wire logic i_key_reverse,
  output logic [15:0] o_speed_ref,
  output logic [4:0] o_step,
  output logic o_run,
  output logic o_reverse,
  output logic o_conflict_err,
  output logic o_irq
);
  //--------------------------------------------------------------------------
  // State
  //--------------------------------------------------------------------------
  typedef struct packed {
    srs_pkg::srs_term_t sync1;
    srs_pkg::srs_term_t sync2;
    logic [2:0] ref_src;
    logic run_src;
    logic two_wire;
    logic [2:0] an2_fn;
    logic [2:0] pls_fn;
    logic [3:0][7:0] in_fn;
    logic [15:0] scale;
    logic [15:0] jog_ref;
    logic [15:0][15:0] preset;
    logic run;
    logic rev;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [15:0] ref_val;
    logic [4:0] step;
    logic err;
  } srs_state_t;

  srs_state_t s_r;
  srs_state_t s_nxt;
  logic [15:0] pulse_ref;
  logic [3:0] term_vec;
  logic [3:0] idx;
  logic jog;
  logic [15:0] sel;
  logic [16:0] sum;
  logic wr_go;
  logic rd_hit;
  logic [31:0] rd_word;
  logic [1:0] ev;

  // Any input that is on and whose function code matches is an active command
  function automatic logic fn_active(input logic [3:0][7:0] fn, input logic [3:0] t,
                                     input logic [7:0] code);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < srs_pkg::NUM_INPUTS; k++) begin
      hit = hit | (t[k] & (fn[k] == code));
    end
    return hit;
  endfunction : fn_active

  function automatic logic fn_used(input logic [3:0][7:0] fn, input logic [7:0] code);
    return fn_active(fn, 4'hf, code);
  endfunction : fn_used

  srs_pulse_meter #(
    .GATE_CYC(GATE_CYC)
  ) u_pulse (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_pulse(s_r.sync2.pulse_train_in),
    .i_scale(s_r.scale),
    .o_ref(pulse_ref)
  );

  //--------------------------------------------------------------------------
  // Reference selection
  //--------------------------------------------------------------------------
  always_comb begin
    term_vec = {s_r.sync2.jog_select_terminal, s_r.sync2.step_cmd_two_terminal,
                s_r.sync2.step_cmd_one_alt_terminal, s_r.sync2.step_cmd_three_terminal};
    idx[0] = fn_active(s_r.in_fn, term_vec, srs_pkg::FN_STEP1);
    idx[1] = fn_active(s_r.in_fn, term_vec, srs_pkg::FN_STEP2);
    idx[2] = fn_active(s_r.in_fn, term_vec, srs_pkg::FN_STEP3);
    idx[3] = fn_active(s_r.in_fn, term_vec, srs_pkg::FN_STEP4);
    jog = fn_active(s_r.in_fn, term_vec, srs_pkg::FN_JOG)
        | fn_active(s_r.in_fn, term_vec, srs_pkg::FN_JOG2);
    sum = 17'h00000;
    if (jog) begin
      sel = s_r.jog_ref;
    end else begin
      sel = s_r.preset[idx];
      if (idx == 4'h0) begin
        case (s_r.ref_src)
          srs_pkg::SRC_ANALOG: begin
            // Bias mode adds the second input; first tied to common gives 4-20mA use
            sum = {1'b0, i_analog.analog_voltage_in};
            if (s_r.an2_fn == srs_pkg::AN2_BIAS) begin
              sum = sum + {1'b0, i_analog.analog_volt_current_in};
            end
            sel = sum[16] ? srs_pkg::REF_MAX : sum[15:0];
          end
          srs_pkg::SRC_PULSE: begin
            sel = (s_r.pls_fn == srs_pkg::PLS_FREQ_REF) ? pulse_ref : 16'h0000;
          end
          default: begin
            sel = s_r.preset[0];
          end
        endcase
      end else if (idx == 4'h1 && s_r.an2_fn == srs_pkg::AN2_AUX) begin
        sel = i_analog.analog_volt_current_in;
      end
    end
  end

  //--------------------------------------------------------------------------
  // Register bus
  //--------------------------------------------------------------------------
  always_comb begin
    rd_hit = 1'b1;
    rd_word = 32'h00000000;
    if (i_paddr[7:6] == srs_pkg::ADDR_PRESET[7:6] && i_paddr[1:0] == 2'b00) begin
      rd_word = {16'h0000, s_r.preset[i_paddr[5:2]]};
    end else begin
      case (i_paddr)
        srs_pkg::ADDR_CTRL: begin
          rd_word[srs_pkg::CTRL_REF_LSB +: 3] = s_r.ref_src;
          rd_word[srs_pkg::CTRL_RUN_BIT] = s_r.run_src;
          rd_word[srs_pkg::CTRL_2W_BIT] = s_r.two_wire;
          rd_word[srs_pkg::CTRL_AN2_LSB +: 3] = s_r.an2_fn;
          rd_word[srs_pkg::CTRL_PLS_LSB +: 3] = s_r.pls_fn;
        end
        srs_pkg::ADDR_INFUNC: rd_word = s_r.in_fn;
        srs_pkg::ADDR_SCALE: rd_word = {16'h0000, s_r.scale};
        srs_pkg::ADDR_JOG: rd_word = {16'h0000, s_r.jog_ref};
        srs_pkg::ADDR_STATUS: begin
          rd_word = {5'h00, s_r.err, s_r.rev, s_r.run, 3'h0, s_r.step, s_r.ref_val};
        end
        srs_pkg::ADDR_IRQ_STAT: rd_word = {30'h00000000, s_r.irq_stat};
        srs_pkg::ADDR_IRQ_MASK: rd_word = {30'h00000000, s_r.irq_mask};
        default: rd_hit = 1'b0;
      endcase
    end
  end

  //--------------------------------------------------------------------------
  // Next state
  //--------------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    ev = 2'b00;
    // Second flop is the only reader of the first
    s_nxt.sync1 = i_term;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.ref_val = sel;
    s_nxt.step = jog ? srs_pkg::JOG_STEP : 5'({1'b0, idx} + 5'h01);
    ev[srs_pkg::IRQ_STEP_CHG] = (s_nxt.step != s_r.step);
    s_nxt.err = fn_used(s_r.in_fn, srs_pkg::FN_JOG2) && s_r.two_wire;
    ev[srs_pkg::IRQ_CONFLICT] = s_nxt.err && !s_r.err;

    // Run source: operator keys or two-wire terminals
    if (s_r.run_src == 1'b0) begin
      if (i_key_stop) begin
        s_nxt.run = 1'b0;
      end else if (i_key_run) begin
        s_nxt.run = 1'b1;
      end
      if (i_key_reverse && !s_r.run) begin
        s_nxt.rev = !s_r.rev;
      end
    end else begin
      // Both terminals on is treated as stop to avoid picking a direction
      s_nxt.run = s_r.sync2.run_fwd ^ s_r.sync2.run_rev;
      if (s_nxt.run) begin
        s_nxt.rev = s_r.sync2.run_rev;
      end
    end

    // One wait state: pready rises in the second access cycle
    wr_go = i_psel && i_penable && s_r.pready && i_pwrite && rd_hit;
    s_nxt.pready = i_psel && i_penable && !s_r.pready;
    s_nxt.prdata = (s_nxt.pready && !i_pwrite) ? rd_word : 32'h00000000;
    s_nxt.pslverr = s_nxt.pready && !rd_hit;
    s_nxt.irq_stat = s_r.irq_stat;
    if (wr_go) begin
      if (i_paddr[7:6] == srs_pkg::ADDR_PRESET[7:6]) begin
        s_nxt.preset[i_paddr[5:2]] = i_pwdata[15:0];
      end else begin
        case (i_paddr)
          srs_pkg::ADDR_CTRL: begin
            // Configuration is frozen while the drive runs
            if (!s_r.run) begin
              s_nxt.ref_src = i_pwdata[srs_pkg::CTRL_REF_LSB +: 3];
              s_nxt.run_src = i_pwdata[srs_pkg::CTRL_RUN_BIT];
              s_nxt.two_wire = i_pwdata[srs_pkg::CTRL_2W_BIT];
              s_nxt.an2_fn = i_pwdata[srs_pkg::CTRL_AN2_LSB +: 3];
              s_nxt.pls_fn = i_pwdata[srs_pkg::CTRL_PLS_LSB +: 3];
            end
          end
          srs_pkg::ADDR_INFUNC: begin
            if (!s_r.run) begin
              s_nxt.in_fn = i_pwdata;
            end
          end
          srs_pkg::ADDR_SCALE: begin
            if (!s_r.run) begin
              s_nxt.scale = i_pwdata[15:0];
            end
          end
          srs_pkg::ADDR_JOG: s_nxt.jog_ref = i_pwdata[15:0];
          srs_pkg::ADDR_IRQ_STAT: s_nxt.irq_stat = s_r.irq_stat & ~i_pwdata[1:0];
          srs_pkg::ADDR_IRQ_MASK: s_nxt.irq_mask = i_pwdata[1:0];
          default: begin
          end
        endcase
      end
    end
    // New events win over a clear in the same cycle
    s_nxt.irq_stat = s_nxt.irq_stat | ev;
    s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
  end

  //--------------------------------------------------------------------------
  // Registers
  //--------------------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_r <= '0;
      s_r.ref_src <= srs_pkg::REF_SRC_RST;
      s_r.run_src <= srs_pkg::RUN_SRC_RST;
      s_r.two_wire <= srs_pkg::TWO_WIRE_RST;
      s_r.an2_fn <= srs_pkg::AN2_FN_RST;
      s_r.pls_fn <= srs_pkg::PLS_FN_RST;
      s_r.in_fn <= {srs_pkg::IN7_FN_RST, srs_pkg::IN6_FN_RST,
                    srs_pkg::IN5_FN_RST, srs_pkg::IN4_FN_RST};
      s_r.scale <= srs_pkg::SCALE_RST;
      s_r.step <= 5'h01;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_pready = s_r.pready;
  assign o_prdata = s_r.prdata;
  assign o_pslverr = s_r.pslverr;
  assign o_speed_ref = s_r.ref_val;
  assign o_step = s_r.step;
  assign o_run = s_r.run;
  assign o_reverse = s_r.rev;
  assign o_conflict_err = s_r.err;
  assign o_irq = s_r.irq;
endmodule : srs_top

// >>> rtl/srs_pkg.sv
// Constants, field layout and carrier types of the speed reference selector
//----------------------------------------------------------------------------
// What this block does
// - Source 1 selects the analog inputs
// - Source 0 selects the keypad preset
// - Step one off: first analog, on: second
// - Current loop on second input, bias mode
// - Source 4 selects the pulse train input
// - Scaling frequency equals one hundred percent
// - Sixteen presets plus one jog reference
// - Step commands form binary index, one LSB
// - Jog input overrides all step commands
// - Step 1 is analog or preset one
// - Step 2 is analog two or preset two
// - Codes 3,4,5 steps, 6 jog
// - Code 32 adds fourth step bit
// - Code 69 with two-wire flags conflict
// - Run source defaults 1, locked while running
// - Run source 0 keys, 1 terminals
//----------------------------------------------------------------------------
package srs_pkg;
  // Bus map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_INFUNC = 8'h04;
  localparam logic [7:0] ADDR_SCALE = 8'h08;
  localparam logic [7:0] ADDR_JOG = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
  localparam logic [7:0] ADDR_PRESET = 8'h40;
  // Control register fields
  localparam int CTRL_REF_LSB = 0;
  localparam int CTRL_RUN_BIT = 4;
  localparam int CTRL_2W_BIT = 5;
  localparam int CTRL_AN2_LSB = 8;
  localparam int CTRL_PLS_LSB = 12;
  // Reset values
  localparam logic [2:0] REF_SRC_RST = 3'h1;
  localparam logic RUN_SRC_RST = 1'b1;
  localparam logic TWO_WIRE_RST = 1'b1;
  localparam logic [2:0] AN2_FN_RST = 3'h0;
  localparam logic [2:0] PLS_FN_RST = 3'h0;
  localparam logic [15:0] SCALE_RST = 16'h05a0;
  localparam logic [7:0] IN4_FN_RST = 8'h05;
  localparam logic [7:0] IN5_FN_RST = 8'h03;
  localparam logic [7:0] IN6_FN_RST = 8'h04;
  localparam logic [7:0] IN7_FN_RST = 8'h06;
  // Source and function codes
  localparam logic [2:0] SRC_KEYPAD = 3'h0;
  localparam logic [2:0] SRC_ANALOG = 3'h1;
  localparam logic [2:0] SRC_PULSE = 3'h4;
  localparam logic [2:0] AN2_BIAS = 3'h0;
  localparam logic [2:0] AN2_AUX = 3'h2;
  localparam logic [2:0] PLS_FREQ_REF = 3'h0;
  localparam logic [7:0] FN_STEP1 = 8'h03;
  localparam logic [7:0] FN_STEP2 = 8'h04;
  localparam logic [7:0] FN_STEP3 = 8'h05;
  localparam logic [7:0] FN_JOG = 8'h06;
  localparam logic [7:0] FN_STEP4 = 8'h20;
  localparam logic [7:0] FN_JOG2 = 8'h45;
  localparam int NUM_PRESETS = 16;
  localparam int NUM_INPUTS = 4;
  localparam logic [4:0] JOG_STEP = 5'h11;
  // Reference units: 0.01 % per count, full scale is 100 %
  localparam logic [15:0] REF_FULL = 16'h2710;
  localparam logic [15:0] REF_MAX = 16'hffff;
  // Pulse measurement gate
  localparam int CLK_HZ = 100000000;
  localparam int GATE_TIME_MS = 10;
  localparam int GATE_CYC = GATE_TIME_MS * (CLK_HZ / 1000);
  localparam logic [31:0] REF_PER_COUNT = 32'(1000 / GATE_TIME_MS) * 32'(REF_FULL);
  // Interrupt bits
  localparam int IRQ_CONFLICT = 0;
  localparam int IRQ_STEP_CHG = 1;

  typedef struct packed {
    logic run_fwd;
    logic run_rev;
    logic step_cmd_three_terminal;
    logic step_cmd_one_alt_terminal;
    logic step_cmd_two_terminal;
    logic jog_select_terminal;
    logic pulse_train_in;
  } srs_term_t;

  typedef struct packed {
    logic [15:0] analog_voltage_in;
    logic [15:0] analog_volt_current_in;
  } srs_analog_t;
endpackage : srs_pkg

// >>> rtl/srs_pulse_meter.sv
// Pulse train frequency meter scaled to a percentage reference
`timescale 1ns/1ns
module srs_pulse_meter #(
  parameter int GATE_CYC = srs_pkg::GATE_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_pulse,
  input wire logic [15:0] i_scale,
  output logic [15:0] o_ref
);
  typedef enum logic [1:0] {PM_COUNT = 2'b00, PM_DIV = 2'b01} srs_pm_state_t;
  typedef struct packed {
    srs_pm_state_t st;
    logic prev;
    logic [31:0] gate;
    logic [15:0] edges;
    logic [31:0] num;
    logic [16:0] rem;
    logic [5:0] bits;
    logic [15:0] ref_val;
  } srs_pm_t;

  srs_pm_t s_r;
  srs_pm_t s_nxt;
  logic [16:0] trial;

  always_comb begin
    s_nxt = s_r;
    trial = 17'h00000;
    s_nxt.prev = i_pulse;
    if (i_pulse && !s_r.prev && s_r.edges != 16'hffff) begin
      s_nxt.edges = s_r.edges + 16'h0001;
    end
    case (s_r.st)
      PM_COUNT: begin
        if (s_r.gate >= 32'(GATE_CYC - 1)) begin
          // Edge count times this factor, over scaling Hz, is the reference
          s_nxt.gate = 32'h00000000;
          s_nxt.num = 32'(s_r.edges) * srs_pkg::REF_PER_COUNT;
          s_nxt.edges = (i_pulse && !s_r.prev) ? 16'h0001 : 16'h0000;
          s_nxt.rem = 17'h00000;
          s_nxt.bits = 6'h00;
          s_nxt.st = PM_DIV;
        end else begin
          s_nxt.gate = s_r.gate + 32'h00000001;
        end
      end
      PM_DIV: begin
        // Restoring division, one quotient bit per cycle; well inside the gate
        s_nxt.gate = s_r.gate + 32'h00000001;
        trial = {s_r.rem[15:0], s_r.num[31]};
        s_nxt.num = {s_r.num[30:0], 1'b0};
        if (trial >= {1'b0, i_scale}) begin
          s_nxt.rem = trial - {1'b0, i_scale};
          s_nxt.num[0] = 1'b1;
        end else begin
          s_nxt.rem = trial;
        end
        s_nxt.bits = s_r.bits + 6'h01;
        if (s_r.bits == 6'h1f) begin
          s_nxt.st = PM_COUNT;
          if (i_scale == 16'h0000 || s_nxt.num[31:16] != 16'h0000) begin
            s_nxt.ref_val = srs_pkg::REF_MAX;
          end else begin
            s_nxt.ref_val = s_nxt.num[15:0];
          end
        end
      end
      default: begin
        s_nxt.st = PM_COUNT;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_ref = s_r.ref_val;
endmodule : srs_pulse_meter

// >>> testbench/srs_checker.sv
// Port assertions for the speed reference selector
`timescale 1ns/1ns
module srs_checker (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  input wire logic [31:0] o_prdata,
  input wire logic o_pslverr,
  input wire srs_pkg::srs_term_t i_term,
  input wire logic [4:0] o_step,
  input wire logic o_conflict_err
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  logic acc;
  assign acc = i_psel && i_penable;
  chk_one_wait: assert property (acc && !o_pready |=> o_pready)
    else $error("ready missing after access");
  chk_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("ready held too long");
  chk_ready_cause: assert property (o_pready |-> $past(acc))
    else $error("ready without access");
  chk_rdata_idle: assert property (!o_pready |-> o_prdata == 32'h0)
    else $error("read data outside answer");
  chk_err_ready: assert property (o_pslverr |-> o_pready)
    else $error("slave error without ready");
  chk_jog_wins: assert property (i_term.jog_select_terminal [*3] |=> o_step == 5'h11)
    else $error("jog not selected");
  chk_step_range: assert property (o_step != 5'h0 && o_step <= 5'h11)
    else $error("step out of range");
  // Config writes may remap inputs, so only quiet bus periods count
  chk_step_hold: assert property ((!i_psel && $stable(i_term)) [*4] |-> $stable(o_step))
    else $error("step moved with quiet inputs");
  cover property (o_pslverr);
  cover property (o_step == 5'h11);
  cover property ($rose(o_conflict_err));
endmodule : srs_checker

// >>> testbench/srs_far_side.sv
// Model of the drive's control terminals, analog levels and pulse source
`timescale 1ns/1ns
module srs_far_side (
  input wire logic i_clk,
  output srs_pkg::srs_term_t o_term,
  output srs_pkg::srs_analog_t o_analog
);
  int half = 0;
  int cnt = 0;
  initial begin
    o_term = '0;
    o_analog = '0;
  end
  // Square wave while half is non-zero; the line idles low between trains
  always @(posedge i_clk) begin
    cnt <= (half != 0 && cnt + 1 < 2 * half) ? cnt + 1 : 0;
    o_term.pulse_train_in <= half != 0 && cnt < half;
  end
  // Bits: forward, reverse, jog, step three, step two, step one
  task automatic set_terms(input logic [5:0] b);
    @(posedge i_clk);
    o_term.run_fwd <= b[5];
    o_term.run_rev <= b[4];
    o_term.jog_select_terminal <= b[3];
    o_term.step_cmd_three_terminal <= b[2];
    o_term.step_cmd_two_terminal <= b[1];
    o_term.step_cmd_one_alt_terminal <= b[0];
  endtask : set_terms
  // A current loop ties the first input to common, so it reads zero
  task automatic set_analog(input logic [15:0] a1, input logic [15:0] a2);
    @(posedge i_clk);
    o_analog <= {a1, a2};
  endtask : set_analog
endmodule : srs_far_side

// >>> testbench/speed_reference_selector_test.sv
// Self-checking bench for the speed reference selector
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module speed_reference_selector_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] pa = 8'h0;
  logic [31:0] pwd = 32'h0;
  logic krun = 1'b0;
  logic kstop = 1'b0;
  logic krev = 1'b0;
  logic rdy, slv, run, cerr, irq, rev;
  logic [31:0] prd, rd;
  logic [15:0] sref;
  logic [4:0] step;
  logic [15:0] pre [16];
  srs_pkg::srs_term_t term;
  srs_pkg::srs_analog_t ana;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  srs_top #(.GATE_CYC(200)) dut (.i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_pready(rdy), .o_prdata(prd),
    .o_pslverr(slv), .i_term(term), .i_analog(ana), .i_key_run(krun), .i_key_stop(kstop),
    .i_key_reverse(krev), .o_speed_ref(sref), .o_step(step), .o_run(run), .o_reverse(rev),
    .o_conflict_err(cerr), .o_irq(irq));
  srs_far_side far (.i_clk(clk), .o_term(term), .o_analog(ana));
  task automatic report_and_stop;
    if (err_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    rd = slv ? 32'hdead : prd;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask : rdc
  // Terminal changes need three edges to reach the outputs
  task automatic look(input logic [4:0] s, input logic [15:0] r);
    repeat (4) @(posedge clk);
    `CHK(step, s)
    `CHK(sref, r)
  endtask : look
  function automatic logic [4:0] exp_step(input logic [3:0] ix, input logic jog);
    return jog ? 5'h11 : {1'b0, ix} + 5'h1;
  endfunction : exp_step
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end
  initial begin
    logic [15:0] a1, a2, jv;
    logic [2:0] s;
    logic [3:0] ix;
    void'($urandom(32'hb7ba3228));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rdc(8'h00, 32'h31);
    rdc(8'h04, 32'h06040305);
    rdc(8'h20, 32'hdead);
    apb(1'b1, 8'h00, 32'h30);
    for (int i = 0; i < 16; i++) begin
      pre[i] = 16'($urandom);
      apb(1'b1, 8'h40 + 8'(4 * i), {16'h0, pre[i]});
    end
    jv = 16'($urandom);
    apb(1'b1, 8'h0c, {16'h0, jv});
    for (int i = 0; i < 8; i++) begin
      far.set_terms(6'(i));
      look(exp_step(4'(i), 1'b0), pre[i]);
      far.set_terms(6'h8 | 6'($urandom % 8));
      look(exp_step(4'h0, 1'b1), jv);
    end
    a1 = 16'($urandom % 32'h8000);
    a2 = 16'($urandom % 32'h8000);
    far.set_analog(a1, a2);
    apb(1'b1, 8'h00, 32'h231);
    far.set_terms(6'h0);
    look(5'h1, a1);
    far.set_terms(6'h1);
    look(5'h2, a2);
    apb(1'b1, 8'h00, 32'h31);
    look(5'h2, pre[1]);
    far.set_analog(16'h0, a2);
    far.set_terms(6'h0);
    look(5'h1, a2);
    // 20 pulse edges a gate stand for the scaling frequency
    apb(1'b1, 8'h08, 32'h7d0);
    apb(1'b1, 8'h00, 32'h34);
    far.half <= 5;
    repeat (700) @(posedge clk);
    `CHK(sref, srs_pkg::REF_FULL)
    // Any other pulse function leaves no frequency reference
    apb(1'b1, 8'h00, 32'h1034);
    repeat (2) @(posedge clk);
    `CHK(sref, 16'h0000)
    far.half <= 0;
    apb(1'b1, 8'h00, 32'h30);
    apb(1'b1, 8'h04, 32'h06200305);
    for (int i = 0; i < 4; i++) begin
      s = (i == 0) ? 3'h2 : 3'($urandom % 8);
      ix = {s[1], s[2], 1'b0, s[0]};
      far.set_terms({3'h0, s});
      look(exp_step(ix, 1'b0), pre[ix]);
    end
    far.set_terms(6'h0);
    repeat (4) @(posedge clk);
    apb(1'b1, 8'h14, 32'h3);
    apb(1'b1, 8'h18, 32'h1);
    apb(1'b1, 8'h04, 32'h45040305);
    repeat (4) @(posedge clk);
    `CHK({cerr, irq}, 2'b11)
    rdc(8'h14, 32'h1);
    apb(1'b1, 8'h14, 32'h1);
    far.set_terms(6'h1);
    repeat (4) @(posedge clk);
    `CHK({cerr, irq, step}, {2'b10, 5'h2})
    rdc(8'h14, 32'h2);
    apb(1'b1, 8'h00, 32'h10);
    far.set_terms(6'h20);
    repeat (4) @(posedge clk);
    `CHK({cerr, run}, 2'b01)
    apb(1'b1, 8'h00, 32'h0);
    rdc(8'h00, 32'h10);
    rdc(8'h10, {5'h00, 3'b001, 3'h0, 5'h01, pre[0]});
    far.set_terms(6'h10);
    repeat (4) @(posedge clk);
    `CHK({run, rev}, 2'b11)
    // Both run terminals on is taken as stop; direction keeps its last value
    far.set_terms(6'h30);
    repeat (4) @(posedge clk);
    `CHK({run, rev}, 2'b01)
    far.set_terms(6'h0);
    repeat (4) @(posedge clk);
    apb(1'b1, 8'h00, 32'h0);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      krun <= (k == 0);
      kstop <= (k == 1);
      @(posedge clk);
      krun <= 1'b0;
      kstop <= 1'b0;
      repeat (4) @(posedge clk);
      `CHK(run, 1'(k == 0))
    end
    // Direction key acts only while stopped
    @(posedge clk);
    krev <= 1'b1;
    @(posedge clk);
    krev <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(rev, 1'b0)
    report_and_stop();
  end
endmodule : speed_reference_selector_test
bind srs_top srs_checker chk (.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel),
  .i_penable(i_penable), .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
  .i_term(i_term), .o_step(o_step), .o_conflict_err(o_conflict_err));
